// File: src/muxed_bus_pkg.sv
package muxed_bus_pkg;

  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 8;
  localparam int MEM_DEPTH  = 128;

  // Control bit positions within the captured control byte
  localparam int CTRL_SQUARE_BIT   = 3;
  localparam int CTRL_UPDATE_BIT   = 4;
  localparam int CTRL_ALARM_BIT    = 5;
  localparam int CTRL_PERIODIC_BIT = 6;
  // Flag bit positions within the status byte
  localparam int FLAG_UPDATE_BIT   = 4;
  localparam int FLAG_ALARM_BIT    = 5;
  localparam int FLAG_PERIODIC_BIT = 6;
  localparam int FLAG_PENDING_BIT  = 7;

  // Control and status register addresses in the byte space
  localparam logic [7:0] CTRL_ADDR   = 8'h0b;
  localparam logic [7:0] STATUS_ADDR = 8'h0c;

  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] ADDR_RESET  = 8'h00;

  // Reset hold recommendation, for reference of the controller
  localparam int RESET_HOLD_MS     = 200;
  localparam int CLK_MHZ           = 100;
  localparam longint RESET_HOLD_CYCLES = longint'(RESET_HOLD_MS) * 1000 * CLK_MHZ;

  typedef struct packed {
    logic addressStrobe;
    logic dataStrobe;
    logic readWrite;
    logic chipSelect_n;
  } bus_ctrl_type;

  typedef struct packed {
    logic periodicIntEnable;
    logic alarmIntEnable;
    logic updateIntEnable;
    logic squareWaveEnable;
  } int_ctrl_type;

  typedef struct packed {
    logic periodicFlag;
    logic alarmFlag;
    logic interruptPendingFlag;
  } int_flag_type;

endpackage : muxed_bus_pkg

// File: src/muxed_bus_port.sv
// Contract
// - Address strobe falling edge captures bus lines as access address.
// - Next address strobe rising edge discards held address, regardless of select.
// - Paired style: read/write high while data strobe high marks a read.
// - Paired style: read/write low during data strobe marks a write.
// - Separate style: read/write is active-low write enable, data on rising edge.
// - Paired style: drive bus only while data strobe high in a read.
// - Paired style: write data captured on data strobe trailing edge.
// - Separate style: data strobe is active-low output enable for reads.
// - Reset leaves time counters, calendar and RAM contents unchanged.
// - Reset forces periodic, alarm and update interrupt enables to zero.
// - Reset forces periodic, alarm and pending flags to zero.
// - Reset releases the interrupt request output to high impedance.
// - Bus accesses are ignored while reset is low.
// - Reset forces the square-wave enable to zero.
// - With reset held high, control contents persist across power fail.
// - Style strap high selects paired strobes, low selects separate strobes.
// - Unselected cycles still capture address but perform no access.
// - Read ends and bus floats on the data strobe's closing edge.
module muxed_bus_port
  import muxed_bus_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Strap
  input  wire logic                  busStyleSelect,
  // Multiplexed bus
  input  wire bus_ctrl_type          busCtrl,
  input  wire logic [DATA_WIDTH-1:0] muxedBusLinesIn,
  output logic      [DATA_WIDTH-1:0] muxedBusLinesOut,
  output logic                       muxedBusLinesOe,
  // Core interrupt events
  input  wire logic                  periodicEvent,
  input  wire logic                  alarmEvent,
  input  wire logic                  updateEvent,
  // Control and status
  output int_ctrl_type               intCtrl,
  output int_flag_type               intFlags,
  output logic                       irqOut,
  output logic                       irqOe
);

  logic                  strobePrev;
  logic                  dataPrev;
  logic                  rwPrev;
  logic                  addrValid;
  logic [ADDR_WIDTH-1:0] heldAddr;
  logic                  pairedStyle;
  logic                  updateFlag;
  logic                  ramWriteEn;
  logic [DATA_WIDTH-1:0] ramReadData;
  logic                  writeStrobe;
  logic                  readActive;
  logic                  selected;
  logic [DATA_WIDTH-1:0] readByte;

  function automatic logic isAddr(input logic [ADDR_WIDTH-1:0] a,
                                  input logic [ADDR_WIDTH-1:0] target);
    isAddr = (a == target);
  endfunction : isAddr

  ////////////////////////////////////////////////////////////////////////////
  // Edge history and strap

  always_ff @(posedge clk) begin
    strobePrev <= busCtrl.addressStrobe;
    dataPrev   <= busCtrl.dataStrobe;
    rwPrev     <= busCtrl.readWrite;
  end

  // Strap is caught at reset so a mid-cycle change cannot flip the decode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pairedStyle <= busStyleSelect;
    end
  end

  assign selected = !busCtrl.chipSelect_n && rst_n;

  always_comb begin
    if (pairedStyle) begin
      writeStrobe = dataPrev && !busCtrl.dataStrobe && !rwPrev;
    end else begin
      writeStrobe = !rwPrev && busCtrl.readWrite;
    end
  end

  always_comb begin
    if (pairedStyle) begin
      readActive = busCtrl.dataStrobe && busCtrl.readWrite;
    end else begin
      readActive = !busCtrl.dataStrobe && busCtrl.readWrite;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address latch

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addrValid <= 1'b0;
      heldAddr  <= ADDR_RESET;
    end else if (strobePrev && !busCtrl.addressStrobe) begin
      addrValid <= 1'b1;
      heldAddr  <= muxedBusLinesIn;
    end else if (!strobePrev && busCtrl.addressStrobe) begin
      addrValid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and flags

  assign ramWriteEn = writeStrobe && selected && addrValid
                      && !isAddr(heldAddr, CTRL_ADDR) && !isAddr(heldAddr, STATUS_ADDR);

  // Reset high keeps everything, so power fail with reset tied high changes nothing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      intCtrl <= '0;
    end else if (writeStrobe && selected && addrValid && isAddr(heldAddr, CTRL_ADDR)) begin
      intCtrl.periodicIntEnable <= muxedBusLinesIn[CTRL_PERIODIC_BIT];
      intCtrl.alarmIntEnable    <= muxedBusLinesIn[CTRL_ALARM_BIT];
      intCtrl.updateIntEnable   <= muxedBusLinesIn[CTRL_UPDATE_BIT];
      intCtrl.squareWaveEnable  <= muxedBusLinesIn[CTRL_SQUARE_BIT];
    end
  end

  // Only a read may clear flags; a write to the status address must not
  function automatic logic readDone();
    readDone = selected && addrValid && rwPrev && isAddr(heldAddr, STATUS_ADDR)
               && (pairedStyle ? (dataPrev && !busCtrl.dataStrobe)
                               : (!dataPrev && busCtrl.dataStrobe));
  endfunction : readDone

  // Status read clears flags on the read's closing edge; a new event wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      intFlags   <= '0;
      updateFlag <= 1'b0;
    end else begin
      if (periodicEvent) begin
        intFlags.periodicFlag <= 1'b1;
      end else if (readDone()) begin
        intFlags.periodicFlag <= 1'b0;
      end
      if (alarmEvent) begin
        intFlags.alarmFlag <= 1'b1;
      end else if (readDone()) begin
        intFlags.alarmFlag <= 1'b0;
      end
      if (updateEvent) begin
        updateFlag <= 1'b1;
      end else if (readDone()) begin
        updateFlag <= 1'b0;
      end
      intFlags.interruptPendingFlag <=
          (periodicEvent || intFlags.periodicFlag) && intCtrl.periodicIntEnable
          || (alarmEvent || intFlags.alarmFlag) && intCtrl.alarmIntEnable
          || (updateEvent || updateFlag) && intCtrl.updateIntEnable;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqOut <= 1'b0;
      irqOe  <= 1'b0;
    end else begin
      irqOut <= 1'b0;
      irqOe  <= intFlags.interruptPendingFlag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage and read path

  port_ram u_ram (
    .clk       (clk),
    .writeEn   (ramWriteEn),
    .writeAddr (heldAddr),
    .writeData (muxedBusLinesIn),
    .readAddr  (heldAddr),
    .readData  (ramReadData)
  );

  always_comb begin
    if (isAddr(heldAddr, CTRL_ADDR)) begin
      readByte = '0;
      readByte[CTRL_PERIODIC_BIT] = intCtrl.periodicIntEnable;
      readByte[CTRL_ALARM_BIT]    = intCtrl.alarmIntEnable;
      readByte[CTRL_UPDATE_BIT]   = intCtrl.updateIntEnable;
      readByte[CTRL_SQUARE_BIT]   = intCtrl.squareWaveEnable;
    end else if (isAddr(heldAddr, STATUS_ADDR)) begin
      readByte = '0;
      readByte[FLAG_PENDING_BIT]  = intFlags.interruptPendingFlag;
      readByte[FLAG_PERIODIC_BIT] = intFlags.periodicFlag;
      readByte[FLAG_ALARM_BIT]    = intFlags.alarmFlag;
      readByte[FLAG_UPDATE_BIT]   = updateFlag;
    end else begin
      readByte = ramReadData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      muxedBusLinesOe  <= 1'b0;
      muxedBusLinesOut <= '0;
    end else begin
      muxedBusLinesOe  <= readActive && selected && addrValid;
      muxedBusLinesOut <= readByte;
    end
  end

endmodule : muxed_bus_port

// File: src/port_ram.sv
module port_ram
  import muxed_bus_pkg::*;
(
  // Clock
  input  wire logic                  clk,
  // Write side
  input  wire logic                  writeEn,
  input  wire logic [ADDR_WIDTH-1:0] writeAddr,
  input  wire logic [DATA_WIDTH-1:0] writeData,
  // Read side, registered
  input  wire logic [ADDR_WIDTH-1:0] readAddr,
  output logic      [DATA_WIDTH-1:0] readData
);

  logic [DATA_WIDTH-1:0] mem [MEM_DEPTH];

  // Contents hold across reset: no reset on the array
  always_ff @(posedge clk) begin
    if (writeEn) begin
      mem[writeAddr[6:0]] <= writeData;
    end
  end

  always_ff @(posedge clk) begin
    readData <= mem[readAddr[6:0]];
  end

endmodule : port_ram

// File: verif/bus_host_model.sv
module bus_host_model
  import muxed_bus_pkg::*;
(
  // Clock and strap
  input  wire logic                  clk,
  input  wire logic                  paired,
  // Multiplexed bus
  output bus_ctrl_type               busCtrl,
  output logic      [DATA_WIDTH-1:0] busLines,
  input  wire logic [DATA_WIDTH-1:0] devLines,
  input  wire logic                  devOe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drive = 8'h00;
  logic       hostOe = 1'b0;
  // Undriven lines show the inverse of the last byte, never a stale copy
  assign busLines = devOe ? devLines : (hostOe ? drive : ~drive);
  task automatic idle();
    busCtrl = {1'b0, !paired, 1'b1, 1'b1};
    hostOe = 1'b0;
  endtask : idle
  //////////////////////////////////////
  task automatic access(input logic wr, input logic sel, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    busCtrl.addressStrobe = 1'b1;
    busCtrl.chipSelect_n = !sel;
    drive = a;
    hostOe = 1'b1;
    @(negedge clk);
    busCtrl.addressStrobe = 1'b0;
    @(negedge clk);
    if (wr) begin
      drive = d;
      busCtrl.readWrite = 1'b0;
      busCtrl.dataStrobe = 1'b1;
      @(negedge clk);
      busCtrl.dataStrobe = !paired;
      busCtrl.readWrite = !paired;
    end else begin
      hostOe = 1'b0;
      busCtrl.dataStrobe = paired;
      repeat (2) @(posedge clk);
      @(negedge clk);
      q = busLines;
      busCtrl.dataStrobe = !paired;
    end
    @(negedge clk);
    idle();
  endtask : access
endmodule : bus_host_model

// File: verif/muxed_bus_port_sva.sv
module muxed_bus_port_sva
  import muxed_bus_pkg::*;
(
  // Clock, reset, strap
  input wire logic         clk,
  input wire logic         rst_n,
  input wire logic         busStyleSelect,
  // Bus
  input wire bus_ctrl_type busCtrl,
  input wire logic         muxedBusLinesOe,
  // Control and status
  input wire int_ctrl_type intCtrl,
  input wire int_flag_type intFlags,
  input wire logic         irqOut,
  input wire logic         irqOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  wire pRd = busCtrl.dataStrobe & busCtrl.readWrite & ~busCtrl.chipSelect_n;
  wire sRd = ~busCtrl.dataStrobe & busCtrl.readWrite & ~busCtrl.chipSelect_n;
  ////////////////////////////////////////
  reset_enables_a: assert property (!rst_n |=> intCtrl[3:1] == 3'h0)
    else $error("enables kept in reset");
  reset_square_a: assert property (!rst_n |=> !intCtrl.squareWaveEnable)
    else $error("square wave kept in reset");
  reset_flags_a: assert property (!rst_n |=> intFlags == 3'h0)
    else $error("flags kept in reset");
  reset_irq_a: assert property (!rst_n |=> !irqOe && !muxedBusLinesOe)
    else $error("outputs driven in reset");
  irq_drive_a: assert property (irqOe |-> irqOut == 1'b0)
    else $error("interrupt line not pulled low");
  paired_read_a: assert property (disable iff (!rst_n) busStyleSelect && pRd |=> muxedBusLinesOe)
    else $error("paired read not driven");
  paired_end_a: assert property (disable iff (!rst_n) busStyleSelect && !pRd |=> !muxedBusLinesOe)
    else $error("paired read not released");
  separate_read_a: assert property (disable iff (!rst_n) !busStyleSelect && sRd |=> muxedBusLinesOe)
    else $error("separate read not driven");
  separate_end_a: assert property (disable iff (!rst_n) !busStyleSelect && !sRd |=> !muxedBusLinesOe)
    else $error("separate read not released");
  ctrl_hold_a: assert property (disable iff (!rst_n) $past(rst_n) && $changed(intCtrl) |->
    !$past(busCtrl.chipSelect_n) || !$past(busCtrl.chipSelect_n, 2))
    else $error("control changed without selected access");
endmodule : muxed_bus_port_sva

bind muxed_bus_port muxed_bus_port_sva chk (.clk(clk), .rst_n(rst_n),
  .busStyleSelect(busStyleSelect), .busCtrl(busCtrl), .muxedBusLinesOe(muxedBusLinesOe),
  .intCtrl(intCtrl), .intFlags(intFlags), .irqOut(irqOut), .irqOe(irqOe));

// File: verif/muxed_bus_port_test.sv
module muxed_bus_port_test
  import muxed_bus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk;
  logic         rst_n;
  logic         busStyleSelect;
  logic         periodicEvent;
  logic         alarmEvent;
  logic         updateEvent;
  logic [7:0]   expByte;
  bus_ctrl_type busCtrl;
  logic [7:0]   busLines;
  logic [7:0]   devOut;
  logic         devOe;
  int_ctrl_type intCtrl;
  int_flag_type intFlags;
  logic         irqOut;
  logic         irqOe;
  int           nMismatch;
  int           cmpCount;
  logic [7:0]   q;
  // Address, data, expected control nibble
  logic [19:0]  rows [6] = '{20'h0b78f, 20'h205af, 20'h7fa5f, 20'h0b489, 20'h0b306, 20'h0b408};
  muxed_bus_port dut (.clk(clk), .rst_n(rst_n), .busStyleSelect(busStyleSelect),
    .busCtrl(busCtrl), .muxedBusLinesIn(busLines), .muxedBusLinesOut(devOut),
    .muxedBusLinesOe(devOe), .periodicEvent(periodicEvent), .alarmEvent(alarmEvent),
    .updateEvent(updateEvent), .intCtrl(intCtrl), .intFlags(intFlags), .irqOut(irqOut),
    .irqOe(irqOe));
  bus_host_model host (.clk(clk), .paired(busStyleSelect), .busCtrl(busCtrl),
    .busLines(busLines), .devLines(devOut), .devOe(devOe));
  //////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic closeOut();
    $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : closeOut
  task automatic pulse(input logic [2:0] ev);
    {periodicEvent, alarmEvent, updateEvent} = ev;
    @(negedge clk);
    {periodicEvent, alarmEvent, updateEvent} = 3'h0;
    repeat (3) @(negedge clk);
  endtask : pulse
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    nMismatch++;
    closeOut();
  end
  initial begin
    rst_n = 1'b0;
    busStyleSelect = 1'b1;
    {periodicEvent, alarmEvent, updateEvent} = 3'h0;
    nMismatch = 0;
    cmpCount = 0;
    host.idle();
    // Short reset, the power-up timer is not modelled
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      host.access(1'b1, 1'b1, rows[i][19:12], rows[i][11:4], q);
      host.access(1'b0, 1'b1, rows[i][19:12], 8'h00, q);
      // Control reads back only its four defined bits
      expByte = (rows[i][19:12] == CTRL_ADDR) ? (rows[i][11:4] & 8'h78) : rows[i][11:4];
      check("read byte", expByte, q);
      check("control", {4'h0, rows[i][3:0]}, {4'h0, intCtrl});
    end
    $display("test table done");
    host.access(1'b1, 1'b0, 8'h20, 8'hff, q);
    host.access(1'b0, 1'b1, 8'h20, 8'h00, q);
    check("unselected", 8'h5a, q);
    $display("test unselected done");
    pulse(3'h7);
    check("irq set", 8'h01, {7'h0, irqOe});
    host.access(1'b0, 1'b1, STATUS_ADDR, 8'h00, q);
    check("status byte", 8'hf0, q);
    repeat (2) @(negedge clk);
    check("flags read", 8'h00, {5'h0, intFlags});
    check("irq released", 8'h00, {7'h0, irqOe});
    $display("test status done");
    // Arm every enable and flag so that reset has something to clear
    host.access(1'b1, 1'b1, CTRL_ADDR, 8'h78, q);
    pulse(3'h7);
    check("armed ctrl", 8'h0f, {4'h0, intCtrl});
    check("armed irq", 8'h01, {7'h0, irqOe});
    rst_n = 1'b0;
    busStyleSelect = 1'b0;
    host.idle();
    host.access(1'b1, 1'b1, 8'h20, 8'h11, q);
    check("enables", 8'h00, {4'h0, intCtrl});
    check("flags", 8'h00, {5'h0, intFlags});
    check("irq", 8'h00, {7'h0, irqOe});
    rst_n = 1'b1;
    $display("test reset done");
    host.access(1'b0, 1'b1, 8'h20, 8'h00, q);
    check("kept byte", 8'h5a, q);
    host.access(1'b1, 1'b1, 8'h21, 8'hc3, q);
    host.access(1'b0, 1'b1, 8'h21, 8'h00, q);
    check("separate byte", 8'hc3, q);
    host.access(1'b1, 1'b1, CTRL_ADDR, 8'h48, q);
    check("separate ctrl", 8'h09, {4'h0, intCtrl});
    $display("test separate done");
    closeOut();
  end
endmodule : muxed_bus_port_test
